// ==== src/uep0_defines.vh ====
`ifndef UEP0_DEFINES_VH
`define UEP0_DEFINES_VH
// register byte addresses on the axi4-lite slave
`define UEP0_IN_CONFIG_ADDR 8'h00
`define UEP0_IN_BCNT_ADDR 8'h04
`define UEP0_OUT_CONFIG_ADDR 8'h08
`define UEP0_OUT_BCNT_ADDR 8'h0C
`define UEP0_STATUS_ADDR 8'h10
`define UEP0_MASK_ADDR 8'h14
// configuration register fields
`define UEP0_CFG_IRQ_EN_BIT 2
`define UEP0_CFG_STALL_BIT 3
`define UEP0_CFG_TOGGLE_BIT 5
`define UEP0_CFG_PERMIT_BIT 7
// byte count register fields
`define UEP0_BCNT_NAK_BIT 7
`define UEP0_BCNT_MAX 4'h8
`define UEP0_CFG_RESET 8'h00
`define UEP0_BCNT_RESET 8'h80
// fixed buffer base locations
`define UEP0_IN_BUF_BASE 16'hFEF8
`define UEP0_OUT_BUF_BASE 16'hFEF0
// status bits
`define UEP0_ST_IN_DONE 0
`define UEP0_ST_OUT_DONE 1
`define UEP0_ST_SETUP 2
// handshake codes
`define UEP0_HS_ACK 2'h0
`define UEP0_HS_NAK 2'h1
`define UEP0_HS_STALL 2'h2
// axi responses
`define UEP0_RESP_OKAY 2'h0
`define UEP0_RESP_SLVERR 2'h2
`endif

// ==== src/uep0_hs_decide.v ====
`timescale 1ns/100ps
`include "uep0_defines.vh"
// handshake choice for one data transaction; stall outranks setup nak
module uep0_hs_decide (
  input wire stall,
  input wire setup_pending,
  input wire nak,
  output wire [1:0] handshake
);
  assign handshake = stall ? `UEP0_HS_STALL : ((setup_pending | nak) ? `UEP0_HS_NAK : `UEP0_HS_ACK);
endmodule // uep0_hs_decide

// ==== src/uep0_ctrl.v ====
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "uep0_defines.vh"
module uep0_ctrl (
  input wire sys_clk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire tok_valid,
  input wire tok_setup,
  input wire tok_in,
  input wire tok_out,
  input wire tok_data_pid,
  output reg hs_valid,
  output reg [1:0] hs_code,
  output reg [3:0] hs_byte_count,
  output reg [15:0] hs_buf_base,
  output reg hs_data_pid,
  output reg in_permit,
  output reg out_permit,
  output reg irq
);
  // clamp reserved counts
  function [3:0] clamp_count;
    input [3:0] c;
    begin
      clamp_count = (c > `UEP0_BCNT_MAX) ? `UEP0_BCNT_MAX : c;
    end
  endfunction

  // true when a write hits an address with byte lane 0 enabled
  function wr_hit;
    input [7:0] a;
    input [7:0] target;
    input lane0;
    begin
      wr_hit = (a == target) & lane0;
    end
  endfunction

  reg [7:0] in_cfg;
  reg [7:0] out_cfg;
  reg [7:0] in_bcnt;
  reg [7:0] out_bcnt;
  reg [2:0] status;
  reg [2:0] mask;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire [1:0] in_hs;
  wire [1:0] out_hs;
  wire do_write;
  wire wr_lane0;
  wire ev_setup;
  wire ev_in_done;
  wire ev_out_done;
  wire [2:0] next_status;

  // data-phase handshake choice, one decoder per direction
  uep0_hs_decide u_in_hs (
    .stall(in_cfg[`UEP0_CFG_STALL_BIT]),
    .setup_pending(status[`UEP0_ST_SETUP]),
    .nak(in_bcnt[`UEP0_BCNT_NAK_BIT]),
    .handshake(in_hs)
  );
  uep0_hs_decide u_out_hs (
    .stall(out_cfg[`UEP0_CFG_STALL_BIT]),
    .setup_pending(status[`UEP0_ST_SETUP]),
    .nak(out_bcnt[`UEP0_BCNT_NAK_BIT]),
    .handshake(out_hs)
  );

  // a write goes ahead once both address and data are held and no write response is still pending
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_lane0 = w_strb[0];
  assign ev_setup = tok_valid & tok_setup;
  // only acked transfers complete; nak or stall leave state untouched
  assign ev_in_done = tok_valid & ~tok_setup & tok_in & (in_hs == `UEP0_HS_ACK);
  assign ev_out_done = tok_valid & ~tok_setup & tok_out & (out_hs == `UEP0_HS_ACK);
  // set wins over write-one-to-clear
  assign next_status = (status & ~((do_write & wr_hit(aw_addr, `UEP0_STATUS_ADDR, wr_lane0)) ? w_data[2:0] : 3'h0))
                     | {ev_setup,
                        ev_out_done & out_cfg[`UEP0_CFG_IRQ_EN_BIT],
                        ev_in_done & in_cfg[`UEP0_CFG_IRQ_EN_BIT]};

  // write address and data channels, taken in either order
  always @(posedge sys_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UEP0_RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid & ~aw_held & ~s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_held & ~s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > `UEP0_MASK_ADDR || aw_addr[1:0] != 2'h0) ? `UEP0_RESP_SLVERR : `UEP0_RESP_OKAY;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register file and endpoint state; hardware updates share the process
  always @(posedge sys_clk) begin
    if (rst) begin
      in_cfg <= `UEP0_CFG_RESET;
      out_cfg <= `UEP0_CFG_RESET;
      in_bcnt <= `UEP0_BCNT_RESET;
      out_bcnt <= `UEP0_BCNT_RESET;
      status <= 3'h0;
      mask <= 3'h0;
    end else begin
      status <= next_status;
      // software fields: permit, stall, enable; toggle keeps, reserved bits clear to zero
      if (do_write & wr_hit(aw_addr, `UEP0_IN_CONFIG_ADDR, wr_lane0)) begin
        in_cfg <= {w_data[7], 1'b0, in_cfg[5], 1'b0, w_data[3:2], 2'b00};
      end
      if (do_write & wr_hit(aw_addr, `UEP0_OUT_CONFIG_ADDR, wr_lane0)) begin
        out_cfg <= {w_data[7], 1'b0, out_cfg[5], 1'b0, w_data[3:2], 2'b00};
      end
      if (do_write & wr_hit(aw_addr, `UEP0_IN_BCNT_ADDR, wr_lane0)) begin
        in_bcnt <= {w_data[7], 3'h0, w_data[3:0]};
      end
      if (do_write & wr_hit(aw_addr, `UEP0_OUT_BCNT_ADDR, wr_lane0)) begin
        out_bcnt <= {w_data[7], 3'h0, w_data[3:0]};
      end
      if (do_write & wr_hit(aw_addr, `UEP0_MASK_ADDR, wr_lane0)) begin
        mask <= w_data[2:0];
      end
      // setup ends stall, rearms both toggles to data1 after setup
      if (ev_setup) begin
        in_cfg[`UEP0_CFG_STALL_BIT] <= 1'b0;
        out_cfg[`UEP0_CFG_STALL_BIT] <= 1'b0;
        in_cfg[`UEP0_CFG_TOGGLE_BIT] <= 1'b1;
        out_cfg[`UEP0_CFG_TOGGLE_BIT] <= 1'b1;
      end
      // completed transfer flips toggle and hands buffer back to nak
      if (ev_in_done) begin
        in_cfg[`UEP0_CFG_TOGGLE_BIT] <= ~in_cfg[`UEP0_CFG_TOGGLE_BIT];
        in_bcnt[`UEP0_BCNT_NAK_BIT] <= 1'b1;
      end
      if (ev_out_done) begin
        out_cfg[`UEP0_CFG_TOGGLE_BIT] <= ~out_cfg[`UEP0_CFG_TOGGLE_BIT];
        out_bcnt[`UEP0_BCNT_NAK_BIT] <= 1'b1;
      end
    end
  end

  // handshake answer to the link side, one cycle after the token
  always @(posedge sys_clk) begin
    if (rst) begin
      hs_valid <= 1'b0;
      hs_code <= `UEP0_HS_ACK;
      hs_byte_count <= 4'h0;
      hs_buf_base <= 16'h0000;
      hs_data_pid <= 1'b0;
      in_permit <= 1'b0;
      out_permit <= 1'b0;
      irq <= 1'b0;
    end else begin
      hs_valid <= tok_valid;
      in_permit <= in_cfg[`UEP0_CFG_PERMIT_BIT];
      out_permit <= out_cfg[`UEP0_CFG_PERMIT_BIT];
      irq <= |(next_status & mask);
      if (tok_valid) begin
        if (tok_setup) begin
          hs_code <= `UEP0_HS_ACK; // setup is never refused
          hs_byte_count <= `UEP0_BCNT_MAX;
          hs_buf_base <= `UEP0_OUT_BUF_BASE;
          hs_data_pid <= 1'b0;
        end else if (tok_in) begin
          hs_code <= in_hs;
          hs_byte_count <= clamp_count(in_bcnt[3:0]);
          hs_buf_base <= `UEP0_IN_BUF_BASE;
          hs_data_pid <= in_cfg[`UEP0_CFG_TOGGLE_BIT];
        end else begin
          hs_code <= out_hs;
          hs_byte_count <= clamp_count(out_bcnt[3:0]);
          hs_buf_base <= `UEP0_OUT_BUF_BASE;
          hs_data_pid <= tok_data_pid;
        end
      end
    end
  end

  // read channel; unmapped or misaligned reads answer slverr with zero
  always @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `UEP0_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid & ~s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `UEP0_RESP_OKAY;
        case (s_axi_araddr)
          `UEP0_IN_CONFIG_ADDR: s_axi_rdata <= {24'h000000, in_cfg};
          `UEP0_IN_BCNT_ADDR: s_axi_rdata <= {24'h000000, in_bcnt};
          `UEP0_OUT_CONFIG_ADDR: s_axi_rdata <= {24'h000000, out_cfg};
          `UEP0_OUT_BCNT_ADDR: s_axi_rdata <= {24'h000000, out_bcnt};
          `UEP0_STATUS_ADDR: s_axi_rdata <= {29'h00000000, status};
          `UEP0_MASK_ADDR: s_axi_rdata <= {29'h00000000, mask};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `UEP0_RESP_SLVERR;
          end
        endcase
      end
    end
  end
endmodule // uep0_ctrl

// ==== verification/uep0_host_model.sv ====
`timescale 1ns/100ps
// host side: issues one endpoint-0 transaction per request
module uep0_host_model (
  input wire sys_clk,
  input wire rst,
  input wire req,
  input wire [1:0] kind,
  input wire pid,
  output reg tok_valid = 1'b0,
  output reg tok_setup = 1'b0,
  output reg tok_in = 1'b0,
  output reg tok_out = 1'b0,
  output reg tok_data_pid = 1'b0
);
  // kind 0 in, 1 out, 2 setup; a nak is only an answer, the caller retries
  always @(posedge sys_clk) begin
    tok_valid <= req & ~rst;
    if (req) begin
      tok_setup <= kind == 2'h2;
      tok_in <= kind == 2'h0;
      tok_out <= kind == 2'h1;
      tok_data_pid <= pid;
    end else begin
      // qualifiers churn between transactions so stale values cannot pass
      tok_setup <= ~tok_setup;
      tok_in <= ~tok_in;
      tok_out <= ~tok_out;
      tok_data_pid <= ~tok_data_pid;
    end
  end
endmodule // uep0_host_model

// ==== verification/uep0_ctrl_assertions.sv ====
`timescale 1ns/100ps
module uep0_ctrl_checker (
  input wire sys_clk,
  input wire rst,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire tok_valid,
  input wire tok_setup,
  input wire tok_in,
  input wire hs_valid,
  input wire [1:0] hs_code,
  input wire [3:0] hs_byte_count,
  input wire [15:0] hs_buf_base,
  input wire hs_data_pid,
  input wire irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  hs_follows_a: assert property (tok_valid |=> hs_valid) else $error("handshake missing");
  hs_stray_a: assert property (!tok_valid |=> !hs_valid) else $error("stray handshake");
  in_base_a: assert property (tok_valid && tok_in && !tok_setup |=> hs_buf_base == 16'hFEF8)
    else $error("wrong in base");
  out_base_a: assert property (tok_valid && !(tok_in && !tok_setup) |=> hs_buf_base == 16'hFEF0)
    else $error("wrong out base");
  count_clamp_a: assert property (hs_valid |-> hs_byte_count <= 4'h8) else $error("count above eight");
  setup_count_a: assert property (tok_valid && tok_setup |=> hs_byte_count == 4'h8 && !hs_data_pid)
    else $error("setup answer wrong");
  setup_nak_a: assert property (tok_valid && tok_setup ##3 tok_valid && !tok_setup |=> hs_code == 2'h1)
    else $error("no nak after setup");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer moved");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
  setup_c: cover property (tok_valid && tok_setup);
  stall_c: cover property (hs_valid && hs_code == 2'h2);
  irq_c: cover property ($rose(irq));
endmodule // uep0_ctrl_checker
bind uep0_ctrl uep0_ctrl_checker chk (.*);

// ==== verification/tb.sv ====
`timescale 1ns/100ps
`include "uep0_defines.vh"
module tb;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] s_axi_awaddr = 8'h00;
  reg [7:0] s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'h1;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg req = 1'b0, pid = 1'b0, tog;
  reg [1:0] kind = 2'h0, r;
  reg [3:0] c;
  reg [31:0] d, seed = 32'd15672;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, hs_valid, hs_data_pid;
  wire tok_valid, tok_setup, tok_in, tok_out, tok_data_pid, in_permit, out_permit, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp, hs_code;
  wire [31:0] s_axi_rdata;
  wire [3:0] hs_byte_count;
  wire [15:0] hs_buf_base;
  integer failures = 0, n_checks = 0, i, k;
  always #50 sys_clk = ~sys_clk;
  uep0_ctrl uut (.*);
  uep0_host_model host (.*);
  function [31:0] xs;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed;
    end
  endfunction
  function [3:0] clampc(input [3:0] v);
    clampc = v > 4'h8 ? 4'h8 : v;
  endfunction
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("Error at %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // bready is raised together with awvalid and wvalid, before bvalid shows
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {xs() & 32'hFFFFFF00} | v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 40; i = i + 1) begin
        @(posedge sys_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bready <= 1'b0;
          i = 99;
        end
      end
      if (i != 100) begin failures = failures + 1; finish_test; end
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 40; i = i + 1) begin
        @(posedge sys_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid && s_axi_rready) begin
          s_axi_rready <= 1'b0;
          d = s_axi_rdata;
          r = s_axi_rresp;
          i = 99;
        end
      end
      if (i != 100) begin failures = failures + 1; finish_test; end
      chk(d, e);
    end
  endtask
  // one host transaction, then wait for its handshake
  task tok(input [1:0] t);
    begin
      @(posedge sys_clk);
      req <= 1'b1;
      kind <= t;
      pid <= xs();
      @(posedge sys_clk);
      req <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge sys_clk);
        #1 if (hs_valid === 1'b1) i = 99;
      end
      if (i != 100) begin failures = failures + 1; finish_test; end
    end
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values, then one unmapped place
    for (k = 0; k < 7; k = k + 1) begin
      rd(8'(k * 4), (k == 1 || k == 3) ? 32'h80 : 32'h0);
      chk(r, k == 6 ? `UEP0_RESP_SLVERR : `UEP0_RESP_OKAY);
    end
    $display("reset test done");
    wr(8'h00, 8'hFF);
    rd(8'h00, 32'h8C);
    chk(in_permit, 1'b1);
    chk(out_permit, 1'b0);
    wr(8'h00, 8'h00);
    // random counts, the first one reserved; ack rearms nak
    tog = 1'b0;
    for (k = 0; k < 6; k = k + 1) begin
      c = k == 0 ? 4'hF : xs();
      wr(8'h04, {4'h0, c});
      tok(2'h0);
      chk(hs_code, `UEP0_HS_ACK);
      chk(hs_byte_count, clampc(c));
      chk(hs_buf_base, `UEP0_IN_BUF_BASE);
      chk(hs_data_pid, tog);
      tog = ~tog;
      tok(2'h0);
      chk(hs_code, `UEP0_HS_NAK);
    end
    wr(8'h0C, 8'h05);
    tok(2'h1);
    chk(hs_code, `UEP0_HS_ACK);
    chk(hs_buf_base, `UEP0_OUT_BUF_BASE);
    chk(hs_data_pid, pid);
    chk(hs_byte_count, 32'h5);
    rd(8'h08, 32'h20);
    $display("count test done");
    // stall, cleared by setup, then setup pending forces nak
    wr(8'h00, 8'h08);
    wr(8'h04, 8'h02);
    tok(2'h0);
    chk(hs_code, `UEP0_HS_STALL);
    tok(2'h2);
    chk(hs_buf_base, `UEP0_OUT_BUF_BASE);
    tok(2'h0);
    chk(hs_code, `UEP0_HS_NAK);
    rd(8'h00, 32'h20);
    $display("stall test done");
    // completion interrupt raised, masked, cleared, then disabled
    wr(8'h10, 8'h07);
    wr(8'h14, 8'h01);
    wr(8'h00, 8'h04);
    tok(2'h0);
    rd(8'h10, 32'h1);
    chk(irq, 1'b1);
    wr(8'h14, 8'h00);
    rd(8'h10, 32'h1);
    chk(irq, 1'b0);
    wr(8'h10, 8'h01);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h01);
    tok(2'h0);
    rd(8'h10, 32'h0);
    $display("irq test done");
    finish_test;
  end
endmodule // tb
